/* File: tb/lbps_far_side.sv */
// Far-side analog model: levels and voltages become comparator flags
// Assumes the bench changes its values away from the rising edge
`timescale 1ns/10ps
module lbps_far_side import lbps_pkg::*; (
  input wire logic mainOk, // Main supply above lockout
  input wire logic battOk, // Backlight supply above lockout
  input wire logic refOk, // Reference in regulation
  input wire logic oc, // Switch current at limit
  input wire logic bGood, // Bias boost good
  input wire logic dDone, // Delay pin charged
  input wire logic signed [31:0] tempC, // Junction temperature
  input wire logic signed [31:0] vo, // Boost output, mV
  input wire logic signed [31:0] vb, // Backlight supply, mV
  input wire logic signed [31:0] det, // Detect pin, mV
  output lbps_cmp_t cmpIn // Comparator flags
);
  assign cmpIn = '{mainOk, battOk, refOk, vo >= vb - 2000, tempC >= 150, tempC < 136, oc,
    vo < vb - 1000, vo >= 39000, bGood, dDone, det > 1100};
endmodule : lbps_far_side

/* File: tb/lbps_sequencer_monitor.sv */
// Checker for the backlight sequencer, port level only
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module lbps_sequencer_monitor import lbps_pkg::*; #(
  parameter int CHANNELS = 6
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Reset, active low
  input wire lbps_cmp_t cmpIn, // Comparator flags
  input wire lbps_chan_t chanIn, // Channel flags
  input wire logic enableIn, // Host enable
  input wire logic dimming_pwm_in, // Dimming input
  input wire logic internalEnable, // Bias enable
  input wire logic panel_reset_n, // Panel reset
  input wire logic ledBoostEn, // Boost enable
  input wire logic ledBoostGate, // Switch drive
  input wire logic [CHANNELS-1:0] sinkEn, // Sink enables
  input wire logic faultLatched // Latched fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Outputs held off by their causes, with the settling delay allowed; short circuit latched
  a_main_low_off: assert property ((!cmpIn.mainUvOk) [*8] |-> !internalEnable && !ledBoostEn)
    else $error("on with main supply low");
  a_enable_low_off: assert property ((!enableIn) [*8] |-> !ledBoostEn && sinkEn == '0)
    else $error("on with enable low");
  a_ref_low_off: assert property ((!cmpIn.refGood) [*8] |-> !ledBoostEn)
    else $error("boost on without reference");
  a_thermal_gate_off: assert property (cmpIn.thermalTrip [*8] |-> !ledBoostGate)
    else $error("switching while hot");
  a_short_latch: assert property ($rose(cmpIn.shortCircuit) && ledBoostEn |-> ##[1:10] faultLatched)
    else $error("short not latched");
  a_latch_holds_off: assert property (faultLatched |=> !ledBoostEn)
    else $error("boost on while latched");
  a_detect_reset: assert property ((!cmpIn.detectOk) [*8] |-> !panel_reset_n)
    else $error("panel reset not asserted");
  a_pin_high_drop: assert property ((|chanIn.pinHigh && $stable(chanIn.pinHigh)) [*8] |-> (sinkEn & chanIn.pinHigh) == '0)
    else $error("high sink pin still on");
  a_dim_low_sinks: assert property ((!dimming_pwm_in) [*8] |-> sinkEn == '0)
    else $error("sinks on with dimming low");
  // Main scenarios reached
  c_boost_on: cover property ($rose(ledBoostEn));
  c_latched: cover property ($rose(faultLatched));
  c_bias_on: cover property ($rose(internalEnable));
endmodule : lbps_sequencer_monitor
bind lbps_sequencer lbps_sequencer_monitor #(.CHANNELS(CHANNELS)) u_mon (.clock, .rst_n, .cmpIn, .chanIn,
  .enableIn, .dimming_pwm_in, .internalEnable, .panel_reset_n, .ledBoostEn, .ledBoostGate, .sinkEn,
  .faultLatched);

/* File: tb/led_backlight_power_sequencer_bench.sv */
// Self-checking bench for the backlight sequencer
// Assumes the far-side model makes the global comparator flags; the bench drives the channel flags
`timescale 1ns/10ps
module led_backlight_power_sequencer_bench import lbps_pkg::*; ();
  logic clock = 0, rst_n = 0, enableIn = 0, dim = 0, flk = 0;
  logic mainOk = 0, battOk = 0, refOk = 0, oc = 0, bGood = 0, dDone = 0;
  int tempC = 25, vo = 12000, vb = 12000, det = 0;
  int fails = 0, n_compared = 0, seed = 32'hA378, ch, latch = 0, excl = 0, hot = 0, armed = 0;
  int tempC_steps[4] = '{160, 140, 130, 25};
  lbps_chan_t chanIn = '0;
  lbps_cmp_t cmpIn;
  logic iEn, dce, sCon, sDis, prn, bEn, clamp, fl, bss;
  logic [5:0] sink, fb;
  logic [7:0] sref;
  // 10 MHz clock
  always #50 clock = ~clock;
  lbps_far_side FAR (.mainOk, .battOk, .refOk, .oc, .bGood, .dDone, .tempC, .vo, .vb, .det, .cmpIn);
  lbps_sequencer #(.CHANNELS(6), .OC_CYCLES(50)) DUT (.clock, .rst_n, .cmpIn, .chanIn, .enableIn,
    .dimming_pwm_in(dim), .flicker_control_in(flk), .internalEnable(iEn), .biasSoftStart(bss),
    .delayChargeEn(dce), .shapeConnect(sCon), .shapeDischarge(sDis), .panel_reset_n(prn),
    .ledBoostEn(bEn), .ledBoostGate(), .ledSoftRef(sref), .clampAtOv(clamp), .sinkEn(sink),
    .feedbackSel(fb), .faultLatched(fl));
  // Compare and count
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Let inputs settle, then compare with the reference model
  task automatic check_led();
    int run;
    repeat (12) @(negedge clock);
    if (tempC >= 150) hot = 1;
    else if (tempC < 136) hot = 0;
    // Latch clears on enable low then high, backlight or main supply loss
    if (latch && !enableIn) armed = 1;
    if ((armed && enableIn) || !battOk || !mainOk) begin
      latch = 0;
      armed = 0;
    end
    run = mainOk && battOk && refOk && vo >= vb - 2000 && enableIn && !latch;
    if (run && vo < vb - 1000) latch = 1;
    run = run && !latch;
    if (run) excl |= chanIn.pinHigh | chanIn.pinShort | (vo >= 39000 ? chanIn.noCurrent : 6'h00);
    // every channel gone shuts the driver
    if (run && (excl & 63) == 63) latch = 1;
    run = run && !latch;
    if (!run) excl = 0;
    chk("ledBoostEn", run && !hot, bEn);
    chk("sinkEn", run && dim ? 6'h3F & ~excl : 0, sink);
    chk("feedbackSel", run ? 6'h3F & ~excl : 0, fb);
    chk("faultLatched", latch, fl);
    chk("biasSoftStart", mainOk && !bGood, bss);
    chk("internalEnable", mainOk, iEn);
    chk("panel_reset_n", mainOk && det > 1100, prn);
  endtask : check_led
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Watchdog
  initial begin
    #4000000;
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1;
    check_led();
    mainOk = 1;
    det = 3000;
    check_led();
    chk("shapeConnect", 0, sCon);
    bGood = 1;
    check_led();
    chk("delayChargeEn", 1, dce);
    dDone = 1;
    check_led();
    chk("shapeConnect", 1, sCon);
    flk = 1;
    check_led();
    chk("shapeDischarge", 1, sDis);
    // dimming held at a steady level
    {battOk, refOk, enableIn, dim} = 4'hF;
    check_led();
    chk("ledSoftRef", 8'h00, sref);
    for (int i = 0; i < 4; i++) begin
      {battOk, refOk, enableIn, dim} = 4'hF ^ (4'h1 << i);
      check_led();
    end
    {battOk, refOk, enableIn, dim} = 4'hF;
    ch = {$random(seed)} % 6;
    chanIn.pinHigh[ch] = 1;
    check_led();
    chanIn.pinHigh = '0;
    check_led();
    vo = 39000;
    chanIn.belowTarget = '1;
    check_led();
    chk("clampAtOv", 1, clamp);
    chanIn.belowTarget = '0;
    chanIn.noCurrent[{$random(seed)} % 6] = 1;
    check_led();
    // Let the soft-start ramp reach its top
    repeat (26000) @(negedge clock);
    chk("ledSoftRef", 8'hFF, sref);
    chanIn.noCurrent = '1;
    check_led();
    chanIn.noCurrent = '0;
    vo = vb;
    enableIn = 0;
    chanIn.pinShort[{$random(seed)} % 6] = 1;
    check_led();
    enableIn = 1;
    check_led();
    foreach (tempC_steps[i]) begin
      tempC = tempC_steps[i];
      check_led();
    end
    oc = 1;
    repeat (80) @(negedge clock);
    oc = 0;
    latch = 1;
    check_led();
    enableIn = 0;
    check_led();
    enableIn = 1;
    check_led();
    vo = vb - 1500;
    check_led();
    vo = vb;
    check_led();
    mainOk = 0;
    det = 0;
    check_led();
    chk("shapeConnect", 1, sCon);
    wrap_up();
  end
endmodule : led_backlight_power_sequencer_bench

/* File: verilog/lbps_consts.svh */
// Constants for the backlight power sequencer: channel count, timing counts
// Assumes a 10 MHz system clock
`ifndef LBPS_CONSTS_SVH
`define LBPS_CONSTS_SVH
`define LBPS_CHANNELS 6
`define LBPS_CLK_HZ 10000000
`define LBPS_BOOST_HZ 1000000
`define LBPS_BOOST_DIV (`LBPS_CLK_HZ / `LBPS_BOOST_HZ)
`define LBPS_OC_MS 16
`define LBPS_OC_CYCLES ((`LBPS_CLK_HZ / 1000) * `LBPS_OC_MS)
`define LBPS_SS_STEPS 8'hFF
`define LBPS_SS_DIV 16'h0064
`endif

/* File: verilog/lbps_pkg.sv */
// Types for the backlight power sequencer
// Assumes lbps_consts.svh is on the include path
`include "lbps_consts.svh"
package lbps_pkg;
  // Backlight sequencer states
  typedef enum logic [1:0] {
    LBPS_OFF = 2'b00,
    LBPS_RUN = 2'b01,
    LBPS_LATCHED = 2'b10
  } lbps_state_t;
  // Per-channel comparator results
  typedef struct packed {
    logic [`LBPS_CHANNELS-1:0] noCurrent;
    logic [`LBPS_CHANNELS-1:0] pinHigh;
    logic [`LBPS_CHANNELS-1:0] pinShort;
    logic [`LBPS_CHANNELS-1:0] belowTarget;
  } lbps_chan_t;
  // Global comparator results
  typedef struct packed {
    logic mainUvOk;
    logic battUvOk;
    logic refGood;
    logic nearInput;
    logic thermalTrip;
    logic thermalRelease;
    logic overCurrent;
    logic shortCircuit;
    logic overVoltage;
    logic biasGood;
    logic delayDone;
    logic detectOk;
  } lbps_cmp_t;
endpackage : lbps_pkg

/* File: verilog/lbps_sequencer.sv */
// Supervisory sequencer for bias supply and six-channel LED backlight
// Assumes comparator and pin inputs are asynchronous; one 10 MHz clock
`timescale 1ns/10ps
// Timing counts and channel count shared with the package
`include "lbps_consts.svh"
module lbps_sequencer import lbps_pkg::*; #(
  parameter int CHANNELS = `LBPS_CHANNELS,
  parameter int OC_CYCLES = `LBPS_OC_CYCLES
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire lbps_cmp_t cmpIn, // Global comparator results
  input wire lbps_chan_t chanIn, // Per-channel comparator results
  input wire logic enableIn, // Backlight enable from host
  input wire logic dimming_pwm_in, // Dimming PWM from host
  input wire logic flicker_control_in, // Flicker control input
  output logic internalEnable, // Bias section enable
  output logic biasSoftStart, // Bias boost soft-start running
  output logic delayChargeEn, // 20 uA charge on shaping delay pin
  output logic shapeConnect, // Shaped gate-high tied to gate-high supply
  output logic shapeDischarge, // Shaped gate-high discharge path
  output logic panel_reset_n, // Panel reset, active low
  output logic ledBoostEn, // Backlight boost enable
  output logic ledBoostGate, // Backlight boost switch drive
  output logic [7:0] ledSoftRef, // Error amplifier reference ramp
  output logic clampAtOv, // Regulate output at overvoltage level
  output logic [CHANNELS-1:0] sinkEn, // Per-channel sink enable
  output logic [CHANNELS-1:0] feedbackSel, // Channels in minimum feedback set
  output logic faultLatched // Backlight latched off
);
  localparam int CW = $bits(lbps_cmp_t) + 4 * CHANNELS + 3;
  localparam logic [23:0] OC_LIMIT = 24'(OC_CYCLES);
  localparam logic [3:0] BOOST_LAST = 4'(`LBPS_BOOST_DIV - 1);

  // Elaboration check on parameters
  if (CHANNELS != `LBPS_CHANNELS || OC_CYCLES < 1 || OC_CYCLES > 24'hFFFFFF) begin : gBadParam
    $error("lbps_sequencer: unsupported parameter value");
  end

  // three-stage synchronisers on all asynchronous inputs
  logic [CW-1:0] rawIn;
  logic [CW-1:0] syncA;
  logic [CW-1:0] syncB;
  logic [CW-1:0] syncC;
  logic [CW-1:0] stable;
  assign rawIn = {cmpIn, chanIn, enableIn, dimming_pwm_in, flicker_control_in};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
      stable <= '0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
      syncC <= syncB;
      stable <= (syncB == syncC) ? syncC : stable;
    end
  end

  // Unpack stable inputs
  lbps_cmp_t cmp;
  lbps_chan_t chan;
  logic enS;
  logic dimS;
  logic flkS;
  assign {cmp, chan, enS, dimS, flkS} = stable;

  // Bias section decode
  logic mainOk;
  logic thermalHold;
  logic shapingOn;
  assign mainOk = cmp.mainUvOk;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      thermalHold <= 1'b0;
    end else if (cmp.thermalTrip) begin
      thermalHold <= 1'b1;
    end else if (cmp.thermalRelease) begin
      thermalHold <= 1'b0;
    end
  end

  // shaping enabled after bias good and delay end
  always_ff @(posedge clock) begin
    if (!rst_n || !mainOk) begin
      shapingOn <= 1'b0;
    end else if (cmp.biasGood && cmp.delayDone) begin
      shapingOn <= 1'b1;
    end
  end

  // Bias outputs
  logic next_shapeConnect;
  logic next_shapeDischarge;
  // detect low or power-up forces shaped output state
  assign next_shapeConnect = !mainOk ? !cmp.detectOk : (!cmp.detectOk || (shapingOn && !flkS));
  // flicker high discharges once shaping runs
  assign next_shapeDischarge = mainOk && cmp.detectOk && shapingOn && flkS;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      internalEnable <= 1'b0;
      biasSoftStart <= 1'b0;
      delayChargeEn <= 1'b0;
      shapeConnect <= 1'b0;
      shapeDischarge <= 1'b0;
      panel_reset_n <= 1'b0;
    end else begin
      // bias bring-up on main supply good
      internalEnable <= mainOk;
      biasSoftStart <= mainOk && !cmp.biasGood;
      delayChargeEn <= mainOk && cmp.biasGood && !shapingOn;
      shapeConnect <= next_shapeConnect;
      shapeDischarge <= next_shapeDischarge;
      // panel reset follows detect and lockout
      panel_reset_n <= mainOk && cmp.detectOk;
    end
  end

  // Backlight enable conditions
  logic condAll;
  logic enPrev;
  logic enRise;
  assign condAll = mainOk && cmp.battUvOk && cmp.refGood && cmp.nearInput && enS;
  assign enRise = enS && !enPrev;

  // Overcurrent persistence counter and channel state
  lbps_state_t state;
  lbps_state_t next_state;
  logic [23:0] ocCount;
  logic ocExpired;
  logic [CHANNELS-1:0] excluded;
  logic allOpen;
  logic running;
  assign running = (state == LBPS_RUN);
  // overcurrent held past limit at full duty
  assign ocExpired = (ocCount >= OC_LIMIT);
  assign allOpen = &excluded;

  // Sequencer next-state decode
  always_comb begin
    next_state = state;
    case (state)
      LBPS_OFF: begin
        if (condAll) begin
          next_state = LBPS_RUN;
        end
      end
      LBPS_RUN: begin
        if (cmp.shortCircuit || ocExpired || (allOpen && ledSoftRef == `LBPS_SS_STEPS)) begin
          next_state = LBPS_LATCHED;
        end else if (!condAll) begin
          next_state = LBPS_OFF;
        end
      end
      LBPS_LATCHED: begin
        // cleared by enable toggle or battery POR
        if (enRise || !cmp.battUvOk) begin
          next_state = LBPS_OFF;
        end
      end
      default: begin
        next_state = LBPS_OFF;
      end
    endcase
  end

  // main supply lockout returns machine to off
  always_ff @(posedge clock) begin
    if (!rst_n || !mainOk) begin
      state <= LBPS_OFF;
      enPrev <= 1'b0;
    end else begin
      state <= next_state;
      enPrev <= enS;
    end
  end

  // counter runs only while overcurrent at full duty
  always_ff @(posedge clock) begin
    if (!rst_n || !running || !(cmp.overCurrent && dimS)) begin
      ocCount <= 24'h000000;
    end else if (!ocExpired) begin
      ocCount <= ocCount + 24'h000001;
    end
  end

  // Per-channel exclusion flags
  for (genvar i = 0; i < CHANNELS; i++) begin : gChan
    always_ff @(posedge clock) begin
      if (!rst_n || !running) begin
        excluded[i] <= 1'b0;
      // open string at overvoltage; pin high; short
      end else if ((cmp.overVoltage && chan.noCurrent[i]) || chan.pinHigh[i] || chan.pinShort[i]) begin
        excluded[i] <= 1'b1;
      end
    end
  end

  // Boost switching period and soft-start
  logic [3:0] phase;
  logic [15:0] ssDiv;
  logic cycleStart;
  logic limitHit;
  logic switchOk;
  assign cycleStart = (phase == 4'h0);
  assign switchOk = running && condAll && !thermalHold;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= 4'h0;
    // fixed 1 MHz period from the system clock
    end else begin
      phase <= (phase == BOOST_LAST) ? 4'h0 : phase + 4'h1;
    end
  end
  // pulse-by-pulse limit held to next cycle start
  // A limit seen on the cycle-start edge wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      limitHit <= 1'b0;
    end else if (cmp.overCurrent) begin
      limitHit <= 1'b1;
    end else if (cycleStart) begin
      limitHit <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !running) begin
      ssDiv <= 16'h0000;
      ledSoftRef <= 8'h00;
    end else if (ledSoftRef != `LBPS_SS_STEPS) begin
      ssDiv <= (ssDiv == `LBPS_SS_DIV) ? 16'h0000 : ssDiv + 16'h0001;
      ledSoftRef <= (ssDiv == `LBPS_SS_DIV) ? ledSoftRef + 8'h01 : ledSoftRef;
    end
  end

  // Backlight outputs
  logic [CHANNELS-1:0] active;
  assign active = ~excluded;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ledBoostEn <= 1'b0;
      ledBoostGate <= 1'b0;
      clampAtOv <= 1'b0;
      sinkEn <= '0;
      feedbackSel <= '0;
      faultLatched <= 1'b0;
    end else begin
      // enable low shuts boost and sinks
      ledBoostEn <= switchOk;
      // gate on at cycle start unless limited
      ledBoostGate <= switchOk && !limitHit && !cmp.overCurrent && !cmp.overVoltage;
      // regulate at threshold while current below target
      clampAtOv <= switchOk && cmp.overVoltage && |(chan.belowTarget & active);
      sinkEn <= (running && condAll && dimS) ? active : '0;
      // feedback minimum over remaining channels only
      feedbackSel <= running ? active : '0;
      faultLatched <= (state == LBPS_LATCHED);
    end
  end
endmodule : lbps_sequencer
